// *** include/ucbrt_defs.svh ***
// Constants for the serial transceiver core: widths, bit positions, counts, reset values
`ifndef UCBRT_DEFS_SVH
`define UCBRT_DEFS_SVH

`define UCBRT_FIFO_DEPTH  16
`define UCBRT_RXE_W       12
`define UCBRT_LCR_W       7
`define UCBRT_IDIV_W      16
`define UCBRT_FDIV_W      6
`define UCBRT_CR_W        14
`define UCBRT_PIN_W       5
`define UCBRT_MDM_W       4

`define UCBRT_CR_EN       0
`define UCBRT_CR_SIR      1
`define UCBRT_CR_LBE      7
`define UCBRT_CR_TXE      8
`define UCBRT_CR_RXE      9
`define UCBRT_CR_DTR      10
`define UCBRT_CR_RTS      11
`define UCBRT_CR_OUT1     12
`define UCBRT_CR_OUT2     13

`define UCBRT_LCR_BRK     0
`define UCBRT_LCR_PEN     1
`define UCBRT_LCR_EPS     2
`define UCBRT_LCR_STP2    3
`define UCBRT_LCR_FEN     4
`define UCBRT_LCR_WLEN_LO 5
`define UCBRT_LCR_WLEN_HI 6

`define UCBRT_RX_FE       8
`define UCBRT_RX_PE       9
`define UCBRT_RX_BE       10
`define UCBRT_RX_OE       11

`define UCBRT_CHK_UART    4'h7
`define UCBRT_CHK_SIR     4'h3
`define UCBRT_SMP_A       4'h6
`define UCBRT_SMP_MID     4'h7
`define UCBRT_SMP_C       4'h8
`define UCBRT_BIT_LAST    4'hf

`define UCBRT_LCR_RST     7'h00
`define UCBRT_IDIV_RST    16'h0000
`define UCBRT_FDIV_RST    6'h00

`endif

// *** include/ucbrt_pkg.sv ***
// Types shared by the serial transceiver core: sequencer states and the core state record
`include "ucbrt_defs.svh"
package ucbrt_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ucbrt_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ucbrt_rx_st_t;

    typedef struct packed {
        logic [`UCBRT_LCR_W-1:0]  lcr;
        logic [`UCBRT_IDIV_W-1:0] idiv;
        logic [`UCBRT_FDIV_W-1:0] fdiv;
        logic [`UCBRT_IDIV_W-1:0] bcnt;
        logic [`UCBRT_FDIV_W-1:0] facc;
        logic                     tick;
        logic [`UCBRT_PIN_W-1:0]  ps1;
        logic [`UCBRT_PIN_W-1:0]  ps2;
        logic [`UCBRT_PIN_W-1:0]  ps3;
        logic [`UCBRT_PIN_W-1:0]  pf;
        logic [`UCBRT_MDM_W-1:0]  mout;
        ucbrt_tx_st_t             tx_st;
        logic [3:0]               tx_cnt;
        logic [2:0]               tx_bit;
        logic [7:0]               tx_sh;
        logic                     tx_par;
        logic                     tx_sb;
        logic                     sout;
        ucbrt_rx_st_t             rx_st;
        logic [3:0]               rx_cnt;
        logic [2:0]               rx_bit;
        logic [7:0]               rx_sh;
        logic [1:0]               smp;
        logic                     rx_pb;
        logic                     rx_armed;
        logic                     ovr;
    } ucbrt_core_t;
endpackage : ucbrt_pkg

// *** logic/ucbrt_fifo.sv ***
// Word FIFO with valid/ready on both sides and a one-entry holding mode
module ucbrt_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         single,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    // Pointers wrap naturally, so DEPTH must be a power of two
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } ucbrt_fifo_st_t;

    ucbrt_fifo_st_t s_q;
    ucbrt_fifo_st_t s_d;
    logic           push;
    logic           pop;

    // Holding mode only flags the bottom entry as space, storage stays physical
    assign in_ready  = single ? (s_q.cnt == '0) : (s_q.cnt != CW'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp          = AW'(s_q.wp + 1'b1);
        end
        if (pop) begin
            s_d.rp = AW'(s_q.rp + 1'b1);
        end
        s_d.cnt = CW'(s_q.cnt + CW'(push) - CW'(pop));
        if (sys_rst) begin
            s_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    property p_fifo_bound;
        @(posedge clk) disable iff (sys_rst)
        s_q.cnt <= CW'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");

    property p_fifo_single;
        @(posedge clk) disable iff (sys_rst)
        single && out_valid && !out_ready |=> !in_ready;
    endproperty
    a_fifo_single: assert property (p_fifo_single) else $error("holding entry accepted 2nd word");
endmodule : ucbrt_fifo

// *** logic/ucbrt_core.sv ***
// Serial transceiver core: baud generator, transmit and receive sequencers, FIFOs, modem pins
// Functional notes
// - Divisor: 16-bit integer plus 6-bit fraction
// - Tick pulses average 16x baud, divided for bits
// - Separate 16-entry FIFOs, receive carries status
// - Enabled transmitter sends until FIFO empties
// - Busy spans FIFO contents and final stop bit
// - Three samples around middle, majority kept
// - Start checked at tick eight, four infrared
// - Data bits every sixteen ticks, then parity
// - Stop low flags framing; push word with flags
// - Entry: data, framing, parity, break, overrun
// - Full FIFO: set overrun, drop shifter word
// - Next stored word carries overrun, then clear
// - FIFOs off: one-entry holding, overrun on unread
// - FIFOs off: write passes to idle shifter
// - Loopback routes serial out into receiver
// - 29-bit line control loaded by one write
// - Modem pins meaningful in terminal or equipment role
module ucbrt_core #(
    parameter int FIFO_DEPTH = `UCBRT_FIFO_DEPTH
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic [`UCBRT_CR_W-1:0]   control_reg,
    input  wire logic                     lcr_wr,
    input  wire logic [`UCBRT_LCR_W-1:0]  line_control_reg,
    input  wire logic [`UCBRT_IDIV_W-1:0] int_divisor_reg,
    input  wire logic [`UCBRT_FDIV_W-1:0] frac_divisor_reg,
    input  wire logic                     dce_mode,
    input  wire logic [7:0]               tx_data,
    input  wire logic                     tx_valid,
    output logic                          tx_ready,
    output logic [`UCBRT_RXE_W-1:0]       rx_data,
    output logic                          rx_valid,
    input  wire logic                     rx_ready,
    output logic                          busy,
    output ucbrt_pkg::ucbrt_tx_st_t       tx_phase,
    output ucbrt_pkg::ucbrt_rx_st_t       rx_phase,
    input  wire logic                     serial_in,
    output logic                          serial_out,
    input  wire logic                     cts_in_n,
    input  wire logic                     dsr_in_n,
    input  wire logic                     carrier_in_n,
    input  wire logic                     ring_in_n,
    output logic [`UCBRT_MDM_W-1:0]       modem_status,
    output logic                          rts_out_n,
    output logic                          dtr_out_n,
    output logic                          aux_out1_n,
    output logic                          aux_out2_n
);
    import ucbrt_pkg::*;

    ucbrt_core_t             s_q;
    ucbrt_core_t             s_d;
    logic                    en;
    logic                    txe;
    logic                    rxe;
    logic                    loopback_enable;
    logic                    brk;
    logic                    pen;
    logic                    eps;
    logic                    stp2;
    logic                    fen;
    logic [1:0]              wlen;
    logic [2:0]              last_bit;
    logic [7:0]              tx_md;
    logic                    txf_valid;
    logic                    txf_pop;
    logic [7:0]              txf_data;
    logic                    tx_end;
    logic                    rx_line;
    logic                    maj;
    logic [3:0]              chk;
    logic [7:0]              rx_word;
    logic                    rx_try;
    logic                    rxf_in_ready;
    logic [`UCBRT_RXE_W-1:0] rxf_in_data;
    logic [`UCBRT_PIN_W-1:0] agree;

    assign en       = control_reg[`UCBRT_CR_EN];
    assign txe      = control_reg[`UCBRT_CR_TXE];
    assign rxe      = control_reg[`UCBRT_CR_RXE];
    assign loopback_enable      = control_reg[`UCBRT_CR_LBE];
    assign chk      = control_reg[`UCBRT_CR_SIR] ? `UCBRT_CHK_SIR : `UCBRT_CHK_UART;
    assign brk      = s_q.lcr[`UCBRT_LCR_BRK];
    assign pen      = s_q.lcr[`UCBRT_LCR_PEN];
    assign eps      = s_q.lcr[`UCBRT_LCR_EPS];
    assign stp2     = s_q.lcr[`UCBRT_LCR_STP2];
    assign fen      = s_q.lcr[`UCBRT_LCR_FEN];
    assign wlen     = s_q.lcr[`UCBRT_LCR_WLEN_HI:`UCBRT_LCR_WLEN_LO];
    assign last_bit = 3'd4 + {1'b0, wlen};

    // Transmit FIFO; with FIFOs off its single entry drains straight into an idle shifter
    ucbrt_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txf (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .single    (~fen),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (txf_valid),
        .out_ready (txf_pop),
        .out_data  (txf_data)
    );

    assign txf_pop = (s_q.tx_st == TX_IDLE) & en & txe & txf_valid;
    assign tx_md   = txf_data & (8'hff >> (2'd3 - wlen));
    assign tx_end  = s_q.tick & (s_q.tx_cnt == `UCBRT_BIT_LAST);

    // Loopback takes the registered line directly, so no synchroniser delay
    assign rx_line = loopback_enable ? s_q.sout : s_q.pf[0];
    assign maj     = (s_q.smp[0] & s_q.smp[1]) | (s_q.smp[0] & rx_line)
                   | (s_q.smp[1] & rx_line);
    assign rx_word = s_q.rx_sh >> (2'd3 - wlen);
    assign rx_try  = (s_q.rx_st == RX_STOP) & s_q.tick & (s_q.rx_cnt == `UCBRT_SMP_C);

    // Break: all-zero word, parity and stop bit
    assign rxf_in_data[`UCBRT_RX_OE] = s_q.ovr;
    assign rxf_in_data[`UCBRT_RX_BE] = (rx_word == 8'h00) & ~maj & ~(pen & s_q.rx_pb);
    assign rxf_in_data[`UCBRT_RX_PE] = pen & (s_q.rx_pb ^ (^rx_word) ^ ~eps);
    assign rxf_in_data[`UCBRT_RX_FE] = ~maj;
    assign rxf_in_data[7:0]          = rx_word;

    ucbrt_fifo #(.W(`UCBRT_RXE_W), .DEPTH(FIFO_DEPTH)) u_rxf (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .single    (~fen),
        .in_valid  (rx_try),
        .in_ready  (rxf_in_ready),
        .in_data   (rxf_in_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    assign agree = ~(s_q.ps2 ^ s_q.ps3);

    always_comb begin
        logic       carry;
        logic       line;
        carry = 1'b0;
        line  = 1'b1;
        s_d   = s_q;

        // Divisors only take effect with the line control write
        if (lcr_wr) begin
            s_d.lcr  = line_control_reg;
            s_d.idiv = int_divisor_reg;
            s_d.fdiv = frac_divisor_reg;
        end

        s_d.ps1  = {ring_in_n, carrier_in_n, dsr_in_n, cts_in_n, serial_in};
        s_d.ps2  = s_q.ps1;
        s_d.ps3  = s_q.ps2;
        s_d.pf   = (agree & s_q.ps2) | (~agree & s_q.pf);
        s_d.mout = ~{control_reg[`UCBRT_CR_OUT2], control_reg[`UCBRT_CR_OUT1],
                     control_reg[`UCBRT_CR_DTR], control_reg[`UCBRT_CR_RTS]};

        // Fraction accumulates; its carry stretches one tick period by a cycle
        s_d.tick = 1'b0;
        if (s_q.idiv == '0) begin
            s_d.bcnt = '0;
        end else if (s_q.bcnt == '0) begin
            {carry, s_d.facc} = s_q.facc + s_q.fdiv;
            s_d.bcnt = s_q.idiv - 16'h1 + {15'h0, carry};
            s_d.tick = 1'b1;
        end else begin
            s_d.bcnt = s_q.bcnt - 16'h1;
        end

        // Transmit: a started frame always completes, even if disabled meanwhile
        if (s_q.tx_st != TX_IDLE && s_q.tick) begin
            s_d.tx_cnt = s_q.tx_cnt + 4'h1;
        end
        unique case (s_q.tx_st)
            TX_IDLE: begin
                if (txf_pop) begin
                    s_d.tx_st  = TX_START;
                    s_d.tx_cnt = 4'h0;
                    s_d.tx_bit = 3'h0;
                    s_d.tx_sb  = 1'b0;
                    s_d.tx_sh  = tx_md;
                    s_d.tx_par = (^tx_md) ^ ~eps;
                end
            end
            TX_START: begin
                if (tx_end) s_d.tx_st = TX_DATA;
            end
            TX_DATA: begin
                if (tx_end) begin
                    s_d.tx_sh  = {1'b1, s_q.tx_sh[7:1]};
                    s_d.tx_bit = s_q.tx_bit + 3'h1;
                    if (s_q.tx_bit == last_bit) s_d.tx_st = pen ? TX_PAR : TX_STOP;
                end
            end
            TX_PAR: begin
                if (tx_end) s_d.tx_st = TX_STOP;
            end
            TX_STOP: begin
                if (tx_end) begin
                    if (stp2 && !s_q.tx_sb) s_d.tx_sb = 1'b1;
                    else s_d.tx_st = TX_IDLE;
                end
            end
            default: s_d.tx_st = TX_IDLE;
        endcase
        unique case (s_d.tx_st)
            TX_START: line = 1'b0;
            TX_DATA:  line = s_d.tx_sh[0];
            TX_PAR:   line = s_d.tx_par;
            default:  line = 1'b1;
        endcase
        s_d.sout = line & ~brk;

        // Receive
        if (s_q.rx_st != RX_IDLE && s_q.tick) begin
            s_d.rx_cnt = s_q.rx_cnt + 4'h1;
            if (s_q.rx_cnt == `UCBRT_SMP_A) s_d.smp[0] = rx_line;
            if (s_q.rx_cnt == `UCBRT_SMP_MID) s_d.smp[1] = rx_line;
        end
        unique case (s_q.rx_st)
            RX_IDLE: begin
                if (rx_line) begin
                    s_d.rx_armed = 1'b1;
                end else if (s_q.rx_armed && en && rxe) begin
                    s_d.rx_st    = RX_START;
                    s_d.rx_cnt   = 4'h0;
                    s_d.rx_bit   = 3'h0;
                    s_d.rx_armed = 1'b0;
                end
            end
            RX_START: begin
                if (s_q.tick && s_q.rx_cnt == chk && rx_line) begin
                    s_d.rx_st    = RX_IDLE;
                    s_d.rx_armed = 1'b1;
                end else if (s_q.tick && s_q.rx_cnt == `UCBRT_BIT_LAST) begin
                    s_d.rx_st = RX_DATA;
                end
            end
            RX_DATA: begin
                if (s_q.tick && s_q.rx_cnt == `UCBRT_SMP_C) s_d.rx_sh = {maj, s_q.rx_sh[7:1]};
                if (s_q.tick && s_q.rx_cnt == `UCBRT_BIT_LAST) begin
                    s_d.rx_bit = s_q.rx_bit + 3'h1;
                    if (s_q.rx_bit == last_bit) s_d.rx_st = pen ? RX_PAR : RX_STOP;
                end
            end
            RX_PAR: begin
                if (s_q.tick && s_q.rx_cnt == `UCBRT_SMP_C) s_d.rx_pb = maj;
                if (s_q.tick && s_q.rx_cnt == `UCBRT_BIT_LAST) s_d.rx_st = RX_STOP;
            end
            RX_STOP: begin
                // Leave at mid stop bit so the next start edge is not missed
                if (rx_try) begin
                    s_d.rx_st = RX_IDLE;
                    s_d.ovr   = ~rxf_in_ready;
                end
            end
            default: s_d.rx_st = RX_IDLE;
        endcase

        if (sys_rst) begin
            s_d      = '0;
            s_d.lcr  = `UCBRT_LCR_RST;
            s_d.idiv = `UCBRT_IDIV_RST;
            s_d.fdiv = `UCBRT_FDIV_RST;
            s_d.ps1  = '1;
            s_d.ps2  = '1;
            s_d.ps3  = '1;
            s_d.pf   = '1;
            s_d.mout = '1;
            s_d.sout = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign busy       = txf_valid | (s_q.tx_st != TX_IDLE);
    assign tx_phase   = s_q.tx_st;
    assign rx_phase   = s_q.rx_st;
    assign serial_out = s_q.sout;
    // Equipment role: pins read as peer request and terminal-ready only
    assign modem_status = dce_mode ? {2'b00, ~s_q.pf[2], ~s_q.pf[1]} : ~s_q.pf[4:1];
    assign rts_out_n  = s_q.mout[0];
    assign dtr_out_n  = s_q.mout[1];
    assign aux_out1_n = s_q.mout[2];
    assign aux_out2_n = s_q.mout[3];

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_busy_fall;
        $fell(busy) |-> $past(s_q.tx_st) == TX_STOP && !txf_valid;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fell before stop bit");

    property p_tick_pulse;
        s_q.tick && s_q.idiv > 16'h1 && !lcr_wr |=> !s_q.tick;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick wider than a cycle");

    property p_tx_go;
        txf_valid && en && txe && s_q.tx_st == TX_IDLE |=> s_q.tx_st == TX_START && !serial_out;
    endproperty
    a_tx_go: assert property (p_tx_go) else $error("queued word did not start");

    property p_idle_high;
        s_q.tx_st == TX_IDLE && !brk |-> serial_out;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle line not high");

    property p_false_start;
        s_q.rx_st == RX_START && s_q.tick && s_q.rx_cnt == chk && rx_line |=> s_q.rx_st == RX_IDLE;
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start kept");

    property p_majority;
        s_q.rx_st == RX_DATA && s_q.tick && s_q.rx_cnt == `UCBRT_SMP_C && s_q.smp == 2'b00
            |=> !s_q.rx_sh[7];
    endproperty
    a_majority: assert property (p_majority) else $error("majority vote wrong");

    property p_ovr_set;
        rx_try && !rxf_in_ready |=> s_q.ovr && s_q.rx_st == RX_IDLE;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun not set");

    property p_ovr_store;
        rx_try && rxf_in_ready && s_q.ovr |-> rxf_in_data[`UCBRT_RX_OE] ##1 !s_q.ovr;
    endproperty
    a_ovr_store: assert property (p_ovr_store) else $error("overrun not stored or kept");

    property p_fe_clear;
        rx_try && rx_line && s_q.smp == 2'b11 |-> !rxf_in_data[`UCBRT_RX_FE];
    endproperty
    a_fe_clear: assert property (p_fe_clear) else $error("framing error on good stop");

    property p_lcr_load;
        lcr_wr |=> s_q.idiv == $past(int_divisor_reg) && s_q.fdiv == $past(frac_divisor_reg);
    endproperty
    a_lcr_load: assert property (p_lcr_load) else $error("divisor not loaded");

    property p_loop;
        loopback_enable && s_q.rx_st == RX_IDLE && s_q.tx_st == TX_START |-> !rx_line;
    endproperty
    a_loop: assert property (p_loop) else $error("loopback not routed");

    c_tx_frame: cover property (s_q.tx_st == TX_STOP ##1 s_q.tx_st == TX_IDLE);
    c_rx_push: cover property (rx_try && rxf_in_ready);
    c_overrun: cover property (rx_try && !rxf_in_ready);
    c_false_start: cover property (s_q.rx_st == RX_START ##1 s_q.rx_st == RX_IDLE);
endmodule : ucbrt_core

// *** verif/ucbrt_remote.sv ***
// Remote serial device: captures frames from the core, sends frames to it
module ucbrt_remote #(
    parameter int BIT = 64
) (
    input  wire logic       clk,
    input  wire logic       line_rx,
    input  wire logic [3:0] nbits,
    output logic            line_tx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] q[$];
    logic [11:0] f;
    // Mid-bit sampling; stop bit is the last sample so the next start edge is not missed
    initial begin
        line_tx = 1'b1;
        forever begin
            @(negedge line_rx);
            f = 12'h000;
            repeat (BIT / 2) @(posedge clk);
            for (int i = 0; i < nbits; i++) begin
                f[i] = line_rx;
                if (i < nbits - 1) repeat (BIT) @(posedge clk);
            end
            q.push_back(f);
        end
    end
    task automatic send(input logic [11:0] fr, input int n);
        for (int i = 0; i < n; i++) begin
            line_tx <= fr[i];
            repeat (BIT) @(posedge clk);
        end
        line_tx <= 1'b1;
    endtask : send
    task automatic glow(input int c);
        line_tx <= 1'b0;
        repeat (c) @(posedge clk);
        line_tx <= 1'b1;
    endtask : glow
endmodule : ucbrt_remote

// *** verif/testbench.sv ***
// Self-checking bench for the serial transceiver core
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, sys_rst = 1'b1, lcr_wr = 1'b0, dce_mode = 1'b0;
    logic tx_valid = 1'b0, rx_ready = 1'b0, pen = 1'b0, eps = 1'b0, stp = 1'b0;
    logic tx_ready, rx_valid, busy, serial_in, serial_out;
    logic rts_out_n, dtr_out_n, aux_out1_n, aux_out2_n;
    logic [13:0] control_reg = 14'h0000;
    logic [6:0]  line_control_reg = 7'h00;
    logic [7:0]  tx_data = 8'h00, d;
    logic [3:0]  mi = 4'hf, modem_status, nb;
    logic [1:0]  wl = 2'h3;
    logic [11:0] rx_data, exq[$];
    int n_fail = 0, n_checks = 0, cyc = 0, seed = 32'heedb2758;
    assign nb = 4'd7 + 4'(wl) + 4'(pen);
    always #4 clk = ~clk;
    ucbrt_core ucbrt_core_i (
        .clk, .sys_rst, .control_reg, .lcr_wr, .line_control_reg,
        .int_divisor_reg(16'h0004), .frac_divisor_reg(6'h04),
        .dce_mode, .tx_data,
        .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .busy, .tx_phase(),
        .rx_phase(), .serial_in, .serial_out, .cts_in_n(mi[0]), .dsr_in_n(mi[1]),
        .carrier_in_n(mi[2]), .ring_in_n(mi[3]), .modem_status, .rts_out_n,
        .dtr_out_n, .aux_out1_n, .aux_out2_n);
    ucbrt_remote ucbrt_remote_i (.clk, .line_rx(serial_out), .nbits(nb), .line_tx(serial_in));
    function automatic logic [7:0] mk();
        return 8'hff >> (3 - wl);
    endfunction : mk
    function automatic logic [11:0] frm(input logic [7:0] v);
        logic [11:0] f;
        f = 12'(v & mk()) << 1;
        if (pen) f[6 + wl] = ^(v & mk()) ^ !eps;
        f[6 + wl + pen] = 1'b1;
        return f;
    endfunction : frm
    task automatic ck(input logic [11:0] got, input logic [11:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s: got %h exp %h", $time, m, got, exp);
        end
    endtask : ck
    task automatic cfg(input logic fen, input logic [13:0] cr);
        @(posedge clk);
        line_control_reg <= {wl, fen, stp, eps, pen, 1'b0};
        lcr_wr <= 1'b1;
        control_reg <= cr;
        @(posedge clk);
        lcr_wr <= 1'b0;
    endtask : cfg
    task automatic put(input logic [7:0] v);
        @(posedge clk);
        tx_data <= v;
        tx_valid <= 1'b1;
        do @(negedge clk); while (tx_ready !== 1'b1);
        @(posedge clk);
        tx_valid <= 1'b0;
        @(negedge clk);
        ck(12'(busy), 12'h001, "busy up");
    endtask : put
    task automatic rd(input logic [11:0] exp, input logic [11:0] m);
        int t = 0;
        do begin @(negedge clk); t++; end while (rx_valid !== 1'b1 && t < 2000);
        ck(12'(rx_valid), 12'h001, "rx valid");
        ck(rx_data & m, exp & m, "rx word");
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask : rd
    task automatic snd(input logic [11:0] f);
        repeat (16) @(posedge clk);
        ucbrt_remote_i.send(f, nb);
    endtask : snd
    task automatic fill(input int n);
        exq.delete();
        repeat (n) begin
            d = 8'($random(seed));
            exq.push_back(frm(d));
            put(d);
        end
    endtask : fill
    task automatic drain();
        int t = 0;
        do begin @(negedge clk); t++; end while (busy !== 1'b0 && t < 15000);
        ck(12'(busy), 12'h000, "busy down");
        foreach (exq[i]) begin
            ck(12'(ucbrt_remote_i.q.size() != 0), 12'h001, "frame count");
            if (ucbrt_remote_i.q.size() != 0) ck(ucbrt_remote_i.q.pop_front(), exq[i], "frame");
        end
    endtask : drain
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            n_fail++;
            $display("ERROR %0t run too long", $time);
            summarize();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        ck({serial_out, busy, tx_ready, rx_valid, rts_out_n, dtr_out_n, aux_out1_n,
            aux_out2_n, modem_status}, 12'haf0, "reset");
        for (int w = 0; w < 12; w++) begin
            wl = 2'(w / 3);
            pen = (w % 3 != 0);
            eps = (w % 3 == 2);
            stp = 1'(w % 2);
            cfg(1'b1, 14'h0301);
            fill(1);
            d = 8'($random(seed));
            snd(frm(d));
            rd({4'h0, d}, {4'hf, mk()});
            snd(frm(d) & ~(12'h001 << (nb - 1)));
            rd({4'h1, d}, {4'h1, mk()});
            snd(12'h000);
            rd(12'h400, {4'h4, mk()});
            if (pen) snd(frm(d) ^ (12'h001 << (nb - 2)));
            if (pen) rd({4'h2, d}, {4'h2, mk()});
            drain();
        end
        pen = 1'b0;
        eps = 1'b0;
        stp = 1'b0;
        for (int ir = 0; ir < 2; ir++) begin
            cfg(1'b1, 14'h0301 | 14'(ir << 1));
            @(posedge clk);
            ucbrt_remote_i.glow(24);
            repeat (1000) @(negedge clk);
            ck(12'(rx_valid), 12'(ir), "short start");
            if (ir == 1) rd(12'h0ff, 12'hfff);
        end
        for (int fe = 1; fe >= 0; fe--) begin
            cfg(1'(fe), 14'h0201);
            fill(fe ? 16 : 1);
            @(negedge clk);
            ck(12'(tx_ready), 12'h000, "tx full");
            @(posedge clk);
            control_reg <= 14'h0301;
            drain();
            fill(2);
            @(negedge clk);
            ck(12'(tx_ready), 12'(fe), "tx held");
            drain();
            cfg(1'(fe), 14'h0301);
            exq.delete();
            for (int i = 0; i <= (fe ? 16 : 1); i++) begin
                d = 8'($random(seed));
                if (i < (fe ? 16 : 1)) exq.push_back({4'h0, d});
                snd(frm(d));
            end
            foreach (exq[i]) rd(exq[i], 12'hfff);
            for (int i = 0; i < 2; i++) begin
                d = 8'($random(seed));
                snd(frm(d));
                rd({i == 0, 3'h0, d}, 12'hfff);
            end
        end
        cfg(1'b1, 14'h0381);
        fill(1);
        rd({4'h0, d}, 12'hfff);
        drain();
        repeat (8) begin
            @(posedge clk);
            control_reg <= {4'($random(seed)), 10'h301};
            mi <= 4'($random(seed));
            dce_mode <= 1'($random(seed));
            repeat (6) @(negedge clk);
            ck(12'({rts_out_n, dtr_out_n, aux_out1_n, aux_out2_n, modem_status}),
               12'({~control_reg[11], ~control_reg[10], ~control_reg[12], ~control_reg[13],
               dce_mode ? {2'b00, ~mi[1:0]} : ~mi}), "modem");
        end
        summarize();
    end
endmodule : testbench
